// ==== hdl/loop_irq_pkg.sv ====
package loop_irq_pkg;

    // ==========================================================
    // register indices and byte addresses (index * 4)
    localparam int unsigned NUM_REGS    = 5;
    localparam logic [15:0] LOCK_IDX    = 16'h0116;
    localparam logic [15:0] STATE_IDX   = 16'h0117;
    localparam logic [15:0] FAST_IDX    = 16'h0118;
    localparam logic [15:0] PROFILE_IDX = 16'h0119;
    localparam logic [15:0] ANALOG_IDX  = 16'h011A;

    localparam logic [11:0] LOCK_ADDR    = {LOCK_IDX[9:0], 2'b00};
    localparam logic [11:0] STATE_ADDR   = {STATE_IDX[9:0], 2'b00};
    localparam logic [11:0] FAST_ADDR    = {FAST_IDX[9:0], 2'b00};
    localparam logic [11:0] PROFILE_ADDR = {PROFILE_IDX[9:0], 2'b00};
    localparam logic [11:0] ANALOG_ADDR  = {ANALOG_IDX[9:0], 2'b00};

    // ==========================================================
    // writable bits per register; the rest are reserved
    localparam logic [7:0] LOCK_WMASK    = 8'hFF;
    localparam logic [7:0] STATE_WMASK   = 8'hFD;
    localparam logic [7:0] FAST_WMASK    = 8'h1C;
    localparam logic [7:0] PROFILE_WMASK = 8'h3F;
    localparam logic [7:0] ANALOG_WMASK  = 8'h1F;
    localparam logic [7:0] ENABLE_RESET  = 8'h00;

    // ==========================================================
    // event fields inside each enable register
    localparam logic [7:0] LOCK_CLAMP_FIELD    = 8'hC0;
    localparam logic [7:0] LOCK_SLEW_FIELD     = 8'h30;
    localparam logic [7:0] LOCK_FREQ_FIELD     = 8'h0C;
    localparam logic [7:0] LOCK_PHASE_FIELD    = 8'h03;
    localparam logic [7:0] STATE_SWITCH_FIELD  = 8'h80;
    localparam logic [7:0] STATE_MODE_FIELD    = 8'h60;
    localparam logic [7:0] STATE_HITLESS_FIELD = 8'h18;
    localparam logic [7:0] STATE_HISTORY_FIELD = 8'h04;
    localparam logic [7:0] STATE_STEP_FIELD    = 8'h01;
    localparam logic [7:0] FAST_RESYNC_FIELD   = 8'h10;
    localparam logic [7:0] FAST_ACQ_FIELD      = 8'h0C;
    localparam logic [7:0] PROFILE_ACT_FIELD   = 8'h3F;
    localparam logic [7:0] ANALOG_DIST_FIELD   = 8'h10;
    localparam logic [7:0] ANALOG_LOCK_FIELD   = 8'h0C;
    localparam logic [7:0] ANALOG_CAL_FIELD    = 8'h03;

    // index 0 = lock ... index 4 = analog
    localparam logic [NUM_REGS-1:0][11:0] REG_ADDR =
        {ANALOG_ADDR, PROFILE_ADDR, FAST_ADDR, STATE_ADDR, LOCK_ADDR};
    localparam logic [NUM_REGS-1:0][7:0] REG_WMASK =
        {ANALOG_WMASK, PROFILE_WMASK, FAST_WMASK, STATE_WMASK, LOCK_WMASK};

    // ==========================================================
    // carriers
    typedef logic [NUM_REGS-1:0][7:0] bank_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

// ==== hdl/loop_ch1_irq_mask_bank.sv ====
`timescale 1ns/1ps
// Behaviour
// - lock reg bit7 enables clamp-inactive event, bit6 clamp-active event.
// - lock reg bit5 enables slew limiter off event, bit4 slew limiter on.
// - lock reg bit3 enables frequency unlock event, bit2 frequency lock event.
// - lock reg bit1 enables phase unlock event, bit0 phase lock event.
// - state reg bit7 enables reference switched event.
// - state reg bit6 enables free-run entry, bit5 holdover entry.
// - state reg bit4 enables hitless entry, bit3 hitless exit.
// - state reg bit2 enables holdover history updated event.
// - state reg bit0 enables reference phase step event.
// - fast-acq reg bit4 enables feedback divider resynchronized event.
// - fast-acq reg bit3 enables acquisition complete, bit2 acquisition started.
// - profile reg bits 5..0 enable activation of source profile 5..0.
// - analog reg bit4 enables distribution synchronized event.
// - analog reg bit3 enables analog loop unlock, bit2 analog loop lock.
// - analog reg bit1 enables calibration complete, bit0 calibration start.
module loop_ch1_irq_mask_bank (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire loop_irq_pkg::apb_req_t apb_req,
    output loop_irq_pkg::apb_rsp_t     apb_rsp,
    input  wire loop_irq_pkg::bank_t   event_latched,
    output loop_irq_pkg::bank_t        event_pending,
    output logic                       irq_req
);

    // ==========================================================
    // bus decode
    loop_irq_pkg::bank_t                  enable_q;
    logic [loop_irq_pkg::NUM_REGS-1:0]    hit;
    logic                                 setup_phase;
    logic                                 access_phase;
    logic                                 mapped;
    logic                                 wr_fire;
    logic [31:0]                          rd_word;
    logic [7:0]                           rd_byte;
    logic [31:0]                          prdata_q;
    logic                                 pslverr_q;
    logic                                 irq_q;
    loop_irq_pkg::bank_t                  pending_q;
    loop_irq_pkg::bank_t                  pending_d;

    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;
    assign mapped       = |hit;
    // zero wait states: every access completes in its first access cycle
    assign wr_fire      = access_phase && apb_req.pwrite;

    genvar gi;
    generate
        for (gi = 0; gi < loop_irq_pkg::NUM_REGS; gi++) begin : g_reg
            logic [7:0] enable_d;
            assign hit[gi] = (apb_req.paddr == loop_irq_pkg::REG_ADDR[gi]);
            // reserved bits never store, so they always read back zero
            assign enable_d = apb_req.pwdata[7:0] & loop_irq_pkg::REG_WMASK[gi];
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    enable_q[gi] <= loop_irq_pkg::ENABLE_RESET;
                end else if (wr_fire && hit[gi]) begin
                    enable_q[gi] <= enable_d;
                end
            end
        end
    endgenerate

    // ==========================================================
    // read path, sampled in the setup cycle so prdata is a flop
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < loop_irq_pkg::NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_byte = enable_q[i];
            end
        end
    end
    assign rd_word = {24'h000000, rd_byte};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q  <= apb_req.pwrite ? 32'h00000000 : rd_word;
            pslverr_q <= !mapped;
        end
    end

    assign apb_rsp.prdata  = prdata_q;
    assign apb_rsp.pready  = access_phase;
    assign apb_rsp.pslverr = access_phase && pslverr_q;

    // ==========================================================
    // masking; events come in already latched and are cleared elsewhere,
    // so an event latched before its enable fires as soon as enabled
    assign pending_d = event_latched & enable_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            pending_q <= pending_d;
            irq_q     <= |pending_d;
        end
    end

    assign event_pending = pending_q;
    assign irq_req       = irq_q;

    // ==========================================================
    // assertions
    property p_write(int idx);
        @(posedge clk) disable iff (!reset_n)
        (wr_fire && hit[idx])
            |=> (enable_q[idx] == ($past(apb_req.pwdata[7:0])
                & loop_irq_pkg::REG_WMASK[idx]));
    endproperty

    lock_write_a : assert property (p_write(0))
        else $error("lock enable write not stored");
    state_write_a : assert property (p_write(1))
        else $error("state enable write not stored");
    fast_write_a : assert property (p_write(2))
        else $error("fast acquisition enable write not stored");
    profile_write_a : assert property (p_write(3))
        else $error("profile enable write not stored");
    analog_write_a : assert property (p_write(4))
        else $error("analog enable write not stored");

    reserved_zero_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (enable_q[1][1] == 1'b0) && (enable_q[2][7:5] == 3'b000)
            && (enable_q[2][1:0] == 2'b00) && (enable_q[3][7:6] == 2'b00)
            && (enable_q[4][7:5] == 3'b000))
        else $error("reserved enable bit set");

    hold_value_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        !wr_fire |=> $stable(enable_q))
        else $error("enable changed without a write");

    irq_follows_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        |(event_latched & enable_q) |=> irq_req)
        else $error("enabled event did not raise request");

    irq_masked_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (~|(event_latched & enable_q))[*2] |-> ##1 !irq_req)
        else $error("request raised with all events masked");

    read_back_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (setup_phase && !apb_req.pwrite && hit[3]) ##1 access_phase
            |-> apb_rsp.prdata == {24'h000000, $past(enable_q[3])})
        else $error("profile enable read back wrong");

    unmapped_err_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (setup_phase && !mapped) ##1 access_phase |-> apb_rsp.pslverr)
        else $error("unmapped access without error");

    ready_access_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (apb_req.psel && apb_req.penable) |-> apb_rsp.pready)
        else $error("access cycle without ready");

    ready_idle_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        !apb_req.psel |-> !apb_rsp.pready)
        else $error("ready without select");

    err_in_access_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error outside an access cycle");

    upper_zero_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        apb_rsp.prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    mapped_ok_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (setup_phase && mapped) ##1 access_phase |-> !apb_rsp.pslverr)
        else $error("mapped access flagged as error");

    stray_write_a : assert property (
        @(posedge clk) disable iff (!reset_n)
        (wr_fire && !mapped) |=> $stable(enable_q))
        else $error("unmapped write changed an enable");

    property p_read(int idx);
        @(posedge clk) disable iff (!reset_n)
        (setup_phase && !apb_req.pwrite && hit[idx]) ##1 access_phase
            |-> apb_rsp.prdata == {24'h000000, $past(enable_q[idx])};
    endproperty

    lock_read_a : assert property (p_read(0))
        else $error("lock enable read back wrong");
    state_read_a : assert property (p_read(1))
        else $error("state enable read back wrong");
    fast_read_a : assert property (p_read(2))
        else $error("fast acquisition enable read back wrong");
    analog_read_a : assert property (p_read(4))
        else $error("analog enable read back wrong");

    property p_isolate(int idx);
        @(posedge clk) disable iff (!reset_n)
        (wr_fire && !hit[idx]) |=> $stable(enable_q[idx]);
    endproperty

    lock_alone_a : assert property (p_isolate(0))
        else $error("lock enables changed by another write");
    state_alone_a : assert property (p_isolate(1))
        else $error("state enables changed by another write");
    fast_alone_a : assert property (p_isolate(2))
        else $error("fast acquisition enables changed by another write");
    profile_alone_a : assert property (p_isolate(3))
        else $error("profile enables changed by another write");
    analog_alone_a : assert property (p_isolate(4))
        else $error("analog enables changed by another write");

    property p_quiet(int idx);
        @(posedge clk) disable iff (!reset_n)
        (enable_q[idx] == 8'h00) |=> (event_pending[idx] == 8'h00);
    endproperty

    lock_quiet_a : assert property (p_quiet(0))
        else $error("lock event pending while all masked");
    state_quiet_a : assert property (p_quiet(1))
        else $error("state event pending while all masked");
    fast_quiet_a : assert property (p_quiet(2))
        else $error("fast acquisition event pending while all masked");
    profile_quiet_a : assert property (p_quiet(3))
        else $error("profile event pending while all masked");
    analog_quiet_a : assert property (p_quiet(4))
        else $error("analog event pending while all masked");

    // ==========================================================
    // per-rule masking; a field reaches pending only while enabled
    property p_event(int idx, logic [7:0] field);
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> ((event_pending[idx] & field)
            == ($past(event_latched[idx] & enable_q[idx]) & field));
    endproperty

    clamp_event_a : assert property (
        p_event(0, loop_irq_pkg::LOCK_CLAMP_FIELD))
        else $error("clamp event masking wrong");
    slew_event_a : assert property (
        p_event(0, loop_irq_pkg::LOCK_SLEW_FIELD))
        else $error("slew limiter event masking wrong");
    freq_lock_a : assert property (
        p_event(0, loop_irq_pkg::LOCK_FREQ_FIELD))
        else $error("frequency lock event masking wrong");
    phase_lock_a : assert property (
        p_event(0, loop_irq_pkg::LOCK_PHASE_FIELD))
        else $error("phase lock event masking wrong");

    ref_switch_a : assert property (
        p_event(1, loop_irq_pkg::STATE_SWITCH_FIELD))
        else $error("reference switch event masking wrong");
    mode_entry_a : assert property (
        p_event(1, loop_irq_pkg::STATE_MODE_FIELD))
        else $error("mode entry event masking wrong");
    hitless_event_a : assert property (
        p_event(1, loop_irq_pkg::STATE_HITLESS_FIELD))
        else $error("hitless event masking wrong");
    history_event_a : assert property (
        p_event(1, loop_irq_pkg::STATE_HISTORY_FIELD))
        else $error("history event masking wrong");
    phase_step_a : assert property (
        p_event(1, loop_irq_pkg::STATE_STEP_FIELD))
        else $error("phase step event masking wrong");

    resync_event_a : assert property (
        p_event(2, loop_irq_pkg::FAST_RESYNC_FIELD))
        else $error("divider resync event masking wrong");
    fast_acq_a : assert property (
        p_event(2, loop_irq_pkg::FAST_ACQ_FIELD))
        else $error("fast acquisition event masking wrong");

    profile_event_a : assert property (
        p_event(3, loop_irq_pkg::PROFILE_ACT_FIELD))
        else $error("profile event masking wrong");

    dist_sync_a : assert property (
        p_event(4, loop_irq_pkg::ANALOG_DIST_FIELD))
        else $error("distribution sync event masking wrong");
    analog_lock_a : assert property (
        p_event(4, loop_irq_pkg::ANALOG_LOCK_FIELD))
        else $error("analog lock event masking wrong");
    analog_cal_a : assert property (
        p_event(4, loop_irq_pkg::ANALOG_CAL_FIELD))
        else $error("calibration event masking wrong");

    lock_enable_c : cover property (
        @(posedge clk) disable iff (!reset_n) wr_fire && hit[0]);
    irq_rise_c : cover property (
        @(posedge clk) disable iff (!reset_n) $rose(irq_req));
    mask_off_c : cover property (
        @(posedge clk) disable iff (!reset_n) $fell(irq_req));
    unmapped_c : cover property (
        @(posedge clk) disable iff (!reset_n) apb_rsp.pslverr);
    profile_pend_c : cover property (
        @(posedge clk) disable iff (!reset_n) |event_pending[3]);

endmodule

// ==== bench/loop_ch1_irq_mask_bank_tb.sv ====
`timescale 1ns/1ps
module loop_ch1_irq_mask_bank_tb;
    // ==========================================================
    // signals
    logic                   clk;
    logic                   reset_n;
    loop_irq_pkg::apb_req_t req;
    loop_irq_pkg::apb_rsp_t rsp;
    loop_irq_pkg::bank_t    event_latched;
    loop_irq_pkg::bank_t    event_pending;
    loop_irq_pkg::bank_t    ev;
    loop_irq_pkg::bank_t    exp_b;
    logic                   irq_req;
    logic [31:0]            rd;
    logic                   err;
    int                     fail_count;
    int                     samples_checked;
    // writable bits, lock first; reserved bits must never stick
    localparam logic [4:0][7:0] EXP_MASK = {8'h1F, 8'h3F, 8'h1C, 8'hFD, 8'hFF};

    loop_ch1_irq_mask_bank uut (.clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
        .event_latched(event_latched), .event_pending(event_pending), .irq_req(irq_req));

    initial clk = 1'h0;
    always #50 clk = ~clk;

    // ==========================================================
    // tasks
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // waits for pready however long it takes; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        int n;
        @(posedge clk);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'h1);
        chk("access cycles", n, 1);
        d = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the roughly 480 cycles the tests need
    initial begin
        #1000000;
        fail_count++;
        end_of_test();
    end

    // ==========================================================
    // tests
    initial begin
        fail_count = 0;
        samples_checked = 0;
        reset_n = 1'h0;
        req = '0;
        event_latched = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        for (int k = 0; k < 5; k++) begin
            apb(1'h0, loop_irq_pkg::REG_ADDR[k], 32'h0, rd, err);
            chk("reset value", rd, 32'h0);
        end
        $display("test reset values done");
        for (int k = 0; k < 5; k++) begin
            apb(1'h1, loop_irq_pkg::REG_ADDR[k], 32'hFFFF_FFFF, rd, err);
            apb(1'h0, loop_irq_pkg::REG_ADDR[k], 32'h0, rd, err);
            chk("readback", rd, {24'h0, EXP_MASK[k]});
            chk("mapped error", err, 1'h0);
            apb(1'h1, loop_irq_pkg::REG_ADDR[k], 32'h0, rd, err);
        end
        $display("test register access done");
        // one enable at a time, so a swapped bit or register shows up
        for (int k = 0; k < 5; k++) begin
            for (int n = 0; n < 8; n++) begin
                ev = '0;
                ev[k][n] = 1'h1;
                exp_b = '0;
                exp_b[k][n] = EXP_MASK[k][n];
                event_latched <= ev;
                apb(1'h1, loop_irq_pkg::REG_ADDR[k], 32'h1 << n, rd, err);
                repeat (3) @(posedge clk);
                chk("irq enabled", irq_req, EXP_MASK[k][n]);
                chk("pending", event_pending, exp_b);
                event_latched <= ~ev;
                repeat (3) @(posedge clk);
                chk("irq masked", irq_req, 1'h0);
            end
            apb(1'h1, loop_irq_pkg::REG_ADDR[k], 32'h0, rd, err);
        end
        $display("test per-bit masking done");
        apb(1'h1, 12'h46C, 32'hFF, rd, err);
        chk("unmapped write error", err, 1'h1);
        apb(1'h0, 12'h46C, 32'h0, rd, err);
        chk("unmapped read error", err, 1'h1);
        chk("unmapped read data", rd, 32'h0);
        $display("test unmapped done");
        // events already latched fire as soon as enabled, so software clears them
        event_latched <= '1;
        apb(1'h1, loop_irq_pkg::LOCK_ADDR, 32'hFF, rd, err);
        repeat (3) @(posedge clk);
        chk("irq on enable", irq_req, 1'h1);
        event_latched <= '0;
        repeat (3) @(posedge clk);
        chk("irq after clear", irq_req, 1'h0);
        event_latched <= '1;
        repeat (3) @(posedge clk);
        chk("irq before reset", irq_req, 1'h1);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk("irq in reset", irq_req, 1'h0);
        chk("pending in reset", event_pending, 40'h0);
        reset_n <= 1'h1;
        apb(1'h0, loop_irq_pkg::LOCK_ADDR, 32'h0, rd, err);
        chk("lock after reset", rd, 32'h0);
        chk("irq after reset", irq_req, 1'h0);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
